// File: pkg/labfc_pkg.sv
package labfc_pkg;
    // Clock
    localparam int CLK_HZ              = 20_000_000;
    localparam int NS_PER_CLK          = 50;
    // Times in their own units
    localparam int FILT_NS             = 1000;
    localparam int ILIM_WIN_MS         = 1500;
    localparam int RECOVERY_MS         = 100;
    localparam int UVLO_US             = 100;
    localparam int OVP_LONG_MS         = 560;
    localparam int OVP_SHORT_MS        = 50;
    localparam int OVP_RESTORE_MS      = 160;
    localparam int REL_MIN_NS          = 2000;
    localparam int REL_MAX_NS          = 20000;
    localparam int ADAPT_PERIOD_US     = 50;
    localparam int DOWN_PUSH_PERIODS   = 16;
    // Cycle counts: least times round up, longest round down
    localparam int FILT_CYC            = (FILT_NS + NS_PER_CLK - 1) / NS_PER_CLK;
    localparam int ILIM_WIN_CYC        = ILIM_WIN_MS * (CLK_HZ / 1000);
    localparam int RECOVERY_CYC        = RECOVERY_MS * (CLK_HZ / 1000);
    localparam int UVLO_CYC            = UVLO_US * (CLK_HZ / 1_000_000);
    localparam int OVP_LONG_CYC        = OVP_LONG_MS * (CLK_HZ / 1000);
    localparam int OVP_SHORT_CYC       = OVP_SHORT_MS * (CLK_HZ / 1000);
    localparam int OVP_RESTORE_CYC     = OVP_RESTORE_MS * (CLK_HZ / 1000);
    localparam int REL_MIN_CYC         = (REL_MIN_NS + NS_PER_CLK - 1) / NS_PER_CLK;
    localparam int REL_MAX_CYC         = REL_MAX_NS / NS_PER_CLK;
    localparam int ADAPT_PERIOD_CYC    = ADAPT_PERIOD_US * (CLK_HZ / 1_000_000);
    // Adaptive code
    localparam logic [7:0] CODE_MIN     = 8'h00;
    localparam logic [7:0] CODE_MAX     = 8'hff;
    localparam logic [7:0] CODE_INIT    = 8'he1;
    localparam int NUM_SINKS           = 3;

    typedef enum logic [1:0] {
        LABFC_STANDBY  = 2'b00,
        LABFC_STARTUP  = 2'b01,
        LABFC_ACTIVE   = 2'b11,
        LABFC_RECOVERY = 2'b10
    } labfc_state_t;
endpackage

// File: src/labfc_filter.sv
`timescale 1ns/1ps
// ----------------------------------------
// Glitch filter: output follows input only after it stays stable
// ----------------------------------------
module labfc_filter
    import labfc_pkg::*;
#(
    parameter int CYC = FILT_CYC
)
(
    // Clock and reset
    input  wire logic mclk,
    input  wire logic reset_n,
    // Data
    input  wire logic raw,
    output logic      filt
);
    localparam int CW = $clog2(CYC + 1);
    logic [CW-1:0] cnt;

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cnt  <= '0;
            filt <= 1'b0;
        end
        else if (raw == filt)
            cnt <= '0;
        else if (cnt == CW'(CYC - 1))
        begin
            cnt  <= '0;
            filt <= raw;
        end
        else
            cnt <= cnt + 1'b1;
    end
endmodule

// File: src/labfc_ctrl.sv
`timescale 1ns/1ps
module labfc_ctrl
    import labfc_pkg::*;
#(
    parameter int N              = NUM_SINKS,
    parameter int ILIM_WIN       = ILIM_WIN_CYC,
    parameter int RECOVERY       = RECOVERY_CYC,
    parameter int OVP_LONG       = OVP_LONG_CYC,
    parameter int OVP_SHORT      = OVP_SHORT_CYC,
    parameter int OVP_RESTORE    = OVP_RESTORE_CYC,
    parameter int ADAPT_PERIOD   = ADAPT_PERIOD_CYC
)
(
    // Clock and reset
    input  wire logic         mclk,
    input  wire logic         reset_n,
    // Host pins
    input  wire logic         io_supply_enable_in,
    input  wire logic         pwm_in,
    output logic              fault_n,
    // Analog comparators
    input  wire logic [N-1:0] sink_low_cmp,
    input  wire logic [N-1:0] sink_mid_cmp,
    input  wire logic [N-1:0] sink_high_cmp,
    input  wire logic [N-1:0] sink_grounded,
    input  wire logic         base_ilim_hit,
    input  wire logic         switch_node_overvolt,
    input  wire logic         input_overvoltage_raw,
    input  wire logic         input_undervoltage_raw,
    input  wire logic         thermal_shutdown_raw,
    // Converter and sink control
    output logic              converter_en,
    output logic              ilim_raised,
    output logic [7:0]        target_code,
    output logic [N-1:0]      sink_gate,
    output logic [N-1:0]      open_fault,
    output logic [N-1:0]      short_fault,
    output logic              input_undervoltage_fault,
    output logic              input_overvoltage_fault,
    output logic              thermal_shutdown_fault,
    output logic [1:0]        state
);
    // ----------------------------------------
    // Comparator filters
    // ----------------------------------------
    logic [N-1:0] low_f;
    logic [N-1:0] mid_f;
    logic [N-1:0] high_f;

    for (genvar i = 0; i < N; i++)
    begin : g_filt
        labfc_filter #(.CYC(FILT_CYC)) u_low  (.mclk(mclk), .reset_n(reset_n), .raw(sink_low_cmp[i]),
                                               .filt(low_f[i]));
        labfc_filter #(.CYC(FILT_CYC)) u_mid  (.mclk(mclk), .reset_n(reset_n), .raw(sink_mid_cmp[i]),
                                               .filt(mid_f[i]));
        labfc_filter #(.CYC(FILT_CYC)) u_high (.mclk(mclk), .reset_n(reset_n), .raw(sink_high_cmp[i]),
                                               .filt(high_f[i]));
    end

    // ----------------------------------------
    // Supply fault persistence
    // ----------------------------------------
    logic        uv_det;
    logic        ov_det;
    logic [24:0] uv_cnt;
    logic [24:0] ov_cnt;
    logic        ov_fast;
    logic [24:0] active_cnt;
    labfc_state_t st;

    function automatic logic [24:0] sat_inc(input logic [24:0] v);
        sat_inc = (v == '1) ? v : v + 25'h1;
    endfunction

    // Undervoltage: 100 us persistence, any state
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            uv_cnt <= '0;
        else if (!input_undervoltage_raw)
            uv_cnt <= '0;
        else
            uv_cnt <= sat_inc(uv_cnt);
    end
    assign uv_det = (uv_cnt >= 25'(UVLO_CYC));

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            ov_cnt <= '0;
        else if (!input_overvoltage_raw || st != LABFC_ACTIVE)
            ov_cnt <= '0;
        else
            ov_cnt <= sat_inc(ov_cnt);
    end
    assign ov_det = (ov_cnt >= (ov_fast ? 25'(OVP_SHORT) : 25'(OVP_LONG)));

    // Shortened filter after first fault, restored after long enough active run
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            ov_fast <= 1'b0;
        else if (ov_det)
            ov_fast <= 1'b1;
        else if (active_cnt >= 25'(OVP_RESTORE))
            ov_fast <= 1'b0;
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            active_cnt <= '0;
        else if (st != LABFC_ACTIVE)
            active_cnt <= '0;
        else
            active_cnt <= sat_inc(active_cnt);
    end

    logic sys_fault;
    assign sys_fault = uv_det || ov_det || thermal_shutdown_raw;

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            input_undervoltage_fault <= 1'b0;
            input_overvoltage_fault  <= 1'b0;
            thermal_shutdown_fault   <= 1'b0;
        end
        else
        begin
            input_undervoltage_fault <= uv_det;
            input_overvoltage_fault  <= ov_det;
            thermal_shutdown_fault   <= thermal_shutdown_raw;
        end
    end

    // ----------------------------------------
    // Enable pulse measurement
    // ----------------------------------------
    logic [9:0] en_low_cnt;
    logic       en_long;
    logic       en_rise;
    logic       en_prev;

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            en_low_cnt <= '0;
            en_prev    <= 1'b0;
        end
        else
        begin
            en_prev <= io_supply_enable_in;
            if (io_supply_enable_in)
                en_low_cnt <= '0;
            else if (!en_long)
                en_low_cnt <= en_low_cnt + 10'h1;
        end
    end
    assign en_long = (en_low_cnt > 10'(REL_MAX_CYC));
    assign en_rise = io_supply_enable_in && !en_prev;

    // Short low pulse inside window: release latched string faults
    logic release_pulse;
    assign release_pulse = en_rise && (en_low_cnt >= 10'(REL_MIN_CYC)) && !en_long;

    // ----------------------------------------
    // State machine
    // ----------------------------------------
    logic [24:0] rec_cnt;

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            st <= LABFC_STANDBY;
        else
        begin
            case (st)
                LABFC_STANDBY:
                    if (io_supply_enable_in && !sys_fault)
                        st <= LABFC_STARTUP;
                LABFC_STARTUP:
                    if (sys_fault)
                        st <= LABFC_RECOVERY;
                    else
                        st <= LABFC_ACTIVE;
                LABFC_ACTIVE:
                    if (en_long)
                        st <= LABFC_STANDBY;
                    else if (sys_fault)
                        st <= LABFC_RECOVERY;
                LABFC_RECOVERY:
                    if (en_long)
                        st <= LABFC_STANDBY;
                    else if (rec_cnt >= 25'(RECOVERY) && !sys_fault)
                        st <= LABFC_ACTIVE;
                default:
                    st <= LABFC_STANDBY;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            rec_cnt <= '0;
        else if (st != LABFC_RECOVERY)
            rec_cnt <= '0;
        else
            rec_cnt <= sat_inc(rec_cnt);
    end

    // ----------------------------------------
    // Sink exclusion and string faults
    // ----------------------------------------
    logic [N-1:0] grounded;
    logic [N-1:0] enabled;
    logic [N-1:0] in_window;

    // Grounded outputs caught once per start
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            grounded <= '0;
        else if (st == LABFC_STARTUP)
            grounded <= sink_grounded;
    end

    assign enabled   = ~(grounded | open_fault | short_fault);
    assign in_window = enabled & low_f & ~mid_f;

    logic at_max;
    assign at_max = (target_code == CODE_MAX);

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            open_fault  <= '0;
            short_fault <= '0;
        end
        else if (st == LABFC_STANDBY || st == LABFC_STARTUP)
        begin
            open_fault  <= '0;
            short_fault <= '0;
        end
        else if (st == LABFC_ACTIVE)
        begin
            for (int i = 0; i < N; i++)
            begin
                if (enabled[i] && at_max && !low_f[i] && pwm_in)
                    open_fault[i] <= 1'b1;
                else if (release_pulse)
                    open_fault[i] <= 1'b0;
                if (enabled[i] && high_f[i] && |(in_window & ~(N'(1) << i)))
                    short_fault[i] <= 1'b1;
                else if (release_pulse)
                    short_fault[i] <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Adaptive target
    // ----------------------------------------
    logic [15:0] adapt_cnt;
    logic        adapt_tick;
    logic [4:0]  push_cnt;
    logic        any_low;
    logic        all_above;

    assign adapt_tick = (adapt_cnt == 16'(ADAPT_PERIOD - 1));
    assign any_low    = |(enabled & ~low_f);
    assign all_above  = (enabled != '0) && ((enabled & ~mid_f) == '0);

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            adapt_cnt <= '0;
        else if (adapt_tick)
            adapt_cnt <= '0;
        else
            adapt_cnt <= adapt_cnt + 16'h1;
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            push_cnt <= '0;
        else if (adapt_tick)
            push_cnt <= (push_cnt == 5'(DOWN_PUSH_PERIODS - 1)) ? 5'h0 : push_cnt + 5'h1;
    end

    // One code step per period, step is (max-min)/255 of span
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            target_code <= CODE_INIT;
        else if (st != LABFC_ACTIVE)
            target_code <= CODE_INIT;
        else if (adapt_tick && pwm_in)
        begin
            if (any_low && !at_max)
                target_code <= target_code + 8'h01;
            else if (!any_low && (all_above || push_cnt == '0) && target_code != CODE_MIN)
                target_code <= target_code - 8'h01;
            // Otherwise headroom is fine, hold
        end
    end

    // ----------------------------------------
    // Current limit window
    // ----------------------------------------
    // Raised for one window, then base for one window, repeating while base_ilim_hit and converter_en stay high
    logic [24:0] ilim_cnt;
    logic        ilim_busy;

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ilim_cnt    <= '0;
            ilim_busy   <= 1'b0;
            ilim_raised <= 1'b0;
        end
        else if (!ilim_busy)
        begin
            if (base_ilim_hit && converter_en)
            begin
                ilim_busy   <= 1'b1;
                ilim_raised <= 1'b1;
                ilim_cnt    <= '0;
            end
        end
        else if (ilim_cnt == 25'(ILIM_WIN - 1))
        begin
            ilim_cnt <= '0;
            if (ilim_raised)
                ilim_raised <= 1'b0;
            else
                ilim_busy <= 1'b0;
        end
        else
            ilim_cnt <= ilim_cnt + 25'h1;
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            converter_en <= 1'b0;
            sink_gate    <= '0;
            fault_n      <= 1'b1;
            state        <= LABFC_STANDBY;
        end
        else
        begin
            converter_en <= (st == LABFC_ACTIVE) && !switch_node_overvolt;
            sink_gate    <= (st == LABFC_ACTIVE && io_supply_enable_in && pwm_in) ?
                            enabled : '0;
            fault_n      <= !((st == LABFC_RECOVERY) || |open_fault || |short_fault);
            state        <= st;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    property p_ovp_gate;
        @(posedge mclk) disable iff (!reset_n) switch_node_overvolt |=> !converter_en;
    endproperty
    a_ovp_gate: assert property (p_ovp_gate) else $error("converter on with overvoltage");

    property p_recovery_off;
        @(posedge mclk) disable iff (!reset_n) st == LABFC_RECOVERY |=> !converter_en && sink_gate == '0 && !fault_n;
    endproperty
    a_recovery_off: assert property (p_recovery_off) else $error("recovery outputs wrong");

    property p_pwm_follow;
        @(posedge mclk) disable iff (!reset_n)
            st == LABFC_ACTIVE && io_supply_enable_in |=> sink_gate == ($past(pwm_in) ? $past(enabled) : '0);
    endproperty
    a_pwm_follow: assert property (p_pwm_follow) else $error("sink gate not following pwm");

    property p_step_one;
        @(posedge mclk) disable iff (!reset_n)
            st == LABFC_ACTIVE && $past(st) == LABFC_ACTIVE |->
            (target_code - $past(target_code) <= 8'h01) || ($past(target_code) - target_code <= 8'h01);
    endproperty
    a_step_one: assert property (p_step_one) else $error("target moved more than one step");

    property p_hold_window;
        @(posedge mclk) disable iff (!reset_n)
            st == LABFC_ACTIVE && adapt_tick && enabled != '0 && (enabled & ~in_window) == '0
            && push_cnt != '0 |=> target_code == $past(target_code);
    endproperty
    a_hold_window: assert property (p_hold_window) else $error("target moved inside window");

    property p_up_low;
        @(posedge mclk) disable iff (!reset_n)
            st == LABFC_ACTIVE && adapt_tick && pwm_in && any_low && !at_max
            |=> target_code == $past(target_code) + 8'h01;
    endproperty
    a_up_low: assert property (p_up_low) else $error("no step up on low sink");

    property p_string_active;
        @(posedge mclk) disable iff (!reset_n)
            st == LABFC_ACTIVE && !sys_fault && !en_long && (|open_fault || |short_fault) |=> st == LABFC_ACTIVE;
    endproperty
    a_string_active: assert property (p_string_active) else $error("string fault left active");

    property p_uv_persist;
        @(posedge mclk) disable iff (!reset_n) $rose(uv_det) |-> uv_cnt == 25'(UVLO_CYC);
    endproperty
    a_uv_persist: assert property (p_uv_persist) else $error("undervoltage declared early");

    c_recovery: cover property (@(posedge mclk) disable iff (!reset_n) st == LABFC_RECOVERY ##1 st == LABFC_ACTIVE);
    c_open:     cover property (@(posedge mclk) disable iff (!reset_n) $rose(|open_fault));
    c_release:  cover property (@(posedge mclk) disable iff (!reset_n) release_pulse && |short_fault);
    c_ilim:     cover property (@(posedge mclk) disable iff (!reset_n) $fell(ilim_raised));
endmodule

// File: tb/labfc_host.sv
`timescale 1ns/1ps
// ----------------------------------------
// Host model: enable level and brightness PWM
// ----------------------------------------
module labfc_host
(
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       reset_n,
    // Commands from the bench
    input  wire logic       en_req,
    input  wire logic [9:0] duty,
    // Host pins
    output logic            io_supply_enable_in,
    output logic            pwm_in
);
    logic [9:0] cnt;

    // Period of 1000 cycles is 20 kHz, the fastest legal rate
    always_ff @(negedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cnt <= 10'h000;
            pwm_in <= 1'b0;
        end
        else
        begin
            cnt <= (cnt == 10'h3e7) ? 10'h000 : cnt + 10'h001;
            pwm_in <= (cnt < duty);
        end
    end

    // Release pulse length is set by the bench, kept inside 40..400 cycles
    always_ff @(negedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            io_supply_enable_in <= 1'b0;
        else
            io_supply_enable_in <= en_req;
    end
endmodule

// File: tb/tb.sv
`timescale 1ns/1ps
// ----------------------------------------
// Bench for the LED boost and fault control
// ----------------------------------------
module tb;
    import labfc_pkg::*;
    localparam int AP = 200;
    localparam int RC = 300;
    logic       mclk = 1'b0, reset_n = 1'b0, en_req = 1'b0, uv = 1'b0, ts = 1'b0;
    logic       ilim = 1'b0, sov = 1'b0, ov = 1'b0;
    logic [9:0] duty = 10'd1000;
    logic [2:0] lo = 3'h7, mi = 3'h0, hi = 3'h0, gnd = 3'h4;
    logic       io_en, pwm, fault_n, conv_en, uvf, tsf, ilr, ovf;
    logic [7:0] tcode, p;
    logic [2:0] gate, openf, shortf;
    logic [1:0] st;
    int         err_count = 0, comparisons = 0, n, h;

    always #25 mclk = ~mclk;

    labfc_host hst (.mclk(mclk), .reset_n(reset_n), .en_req(en_req), .duty(duty),
                    .io_supply_enable_in(io_en), .pwm_in(pwm));
    labfc_ctrl #(.ILIM_WIN(200), .RECOVERY(RC), .OVP_LONG(400), .OVP_SHORT(200), .OVP_RESTORE(300),
                 .ADAPT_PERIOD(AP)) dut (
        .mclk(mclk), .reset_n(reset_n), .io_supply_enable_in(io_en), .pwm_in(pwm), .fault_n(fault_n),
        .sink_low_cmp(lo), .sink_mid_cmp(mi), .sink_high_cmp(hi), .sink_grounded(gnd),
        .base_ilim_hit(ilim), .switch_node_overvolt(sov), .input_overvoltage_raw(ov),
        .input_undervoltage_raw(uv), .thermal_shutdown_raw(ts), .converter_en(conv_en),
        .ilim_raised(ilr), .target_code(tcode), .sink_gate(gate), .open_fault(openf),
        .short_fault(shortf), .input_undervoltage_fault(uvf), .input_overvoltage_fault(ovf),
        .thermal_shutdown_fault(tsf), .state(st));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task cyc(input int k);
        repeat (k) @(negedge mclk);
    endtask

    task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask

    // Saturating one-code step of the adaptive target
    function logic [7:0] step(input logic [7:0] c, input logic up);
        if (up)
            return (c == 8'hff) ? c : c + 8'h01;
        return (c == 8'h00) ? c : c - 8'h01;
    endfunction

    // Short enable pulse: LEDs dark, state kept, latched faults gone
    task release_pulse;
        int len;
        len = $urandom_range(60, 360);
        en_req = 1'b0;
        cyc(len / 2);
        chk("gate_in_pulse", 8'h00, {5'h0, gate});
        chk("state_in_pulse", {6'h0, LABFC_ACTIVE}, {6'h0, st});
        cyc(len - len / 2);
        en_req = 1'b1;
        cyc(30);
        chk("faults_after", 8'h00, {2'h0, openf, shortf});
        chk("fault_n_after", 8'h01, {7'h0, fault_n});
    endtask

    task summarize;
        $display("errors %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Whole run is near 20000 cycles; twice that means a hang
    initial
    begin
        #2000000;
        err_count++;
        summarize();
    end

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial
    begin
        void'($urandom(32'h1524));
        cyc(2);
        chk("reset_code", 8'he1, tcode);
        chk("reset_pins", 8'h01, {4'h0, conv_en, st, fault_n});
        cyc(1);
        reset_n = 1'b1;
        en_req = 1'b1;
        for (n = 0; n < 10 && st !== LABFC_ACTIVE; n++) cyc(1);
        gnd = 3'h0;
        cyc(40);
        chk("conv_en", 8'h01, {7'h0, conv_en});
        chk("grounded_gate", 8'h03, {5'h0, gate});
        duty = 10'($urandom_range(100, 900));
        h = 0;
        cyc(2);
        for (n = 0; n < 1000; n++)
        begin
            cyc(1);
            h += gate[0];
            if (gate[2] !== 1'b0) h += 5000;
        end
        chk("pwm_duty", 8'h01, {7'h0, h == int'(duty)});
        duty = 10'd1000;
        mi = 3'h7;
        p = tcode;
        for (n = 0; n < 2 * AP + 40 && tcode === p; n++) cyc(1);
        chk("step_down", step(p, 1'b0), tcode);
        mi = 3'h0;
        cyc(40);
        p = tcode;
        cyc(17 * AP + 40);
        chk("hold_push", 8'h01, {7'h0, tcode < p && tcode >= p - 8'h02});
        lo = 3'h6;
        cyc(40);
        p = tcode;
        for (n = 0; n < 2 * AP + 40 && tcode === p; n++) cyc(1);
        chk("step_up", step(p, 1'b1), tcode);
        for (n = 0; n < 300 * AP && openf !== 3'h1; n++) cyc(1);
        cyc(4);
        chk("open_code", 8'hff, tcode);
        chk("open_flags", 8'h01, {5'h0, openf});
        chk("open_gate", 8'h02, {5'h0, gate});
        chk("open_pin", {5'h0, LABFC_ACTIVE, 1'b0}, {5'h0, st, fault_n});
        lo = 3'h7;
        release_pulse();
        mi = 3'h2;
        hi = 3'h2;
        cyc(60);
        chk("short_flags", 8'h02, {5'h0, shortf});
        chk("short_gate", 8'h01, {5'h0, gate});
        hi = 3'h0;
        mi = 3'h0;
        release_pulse();
        ts = 1'b1;
        for (n = 0; n < 60 && st !== LABFC_RECOVERY; n++) cyc(1);
        cyc(2);
        chk("recovery_out", 8'h01, {3'h0, conv_en, gate, tsf});
        chk("recovery_pin", 8'h00, {7'h0, fault_n});
        cyc(30);
        ts = 1'b0;
        for (n = 32; n < RC + 200 && st !== LABFC_ACTIVE; n++) cyc(1);
        chk("recovery_len", 8'h01, {7'h0, n >= RC && n < RC + 100});
        cyc(3);
        chk("recovered_pin", 8'h01, {7'h0, fault_n});
        uv = 1'b1;
        cyc(1500);
        chk("uv_early", 8'h00, {7'h0, uvf});
        for (n = 0; n < 700 && uvf !== 1'b1; n++) cyc(1);
        cyc(3);
        chk("uv_state", {6'h0, LABFC_RECOVERY}, {6'h0, st});
        uv = 1'b0;
        for (n = 0; n < RC + 2500 && st !== LABFC_ACTIVE; n++) cyc(1);
        en_req = 1'b0;
        cyc(500);
        chk("standby", {6'h0, LABFC_STANDBY}, {6'h0, st});
        en_req = 1'b1;
        for (n = 0; n < 10 && st !== LABFC_ACTIVE; n++) cyc(1);
        chk("restart", {6'h0, LABFC_ACTIVE}, {6'h0, st});
        // Continuous overcurrent: raised, base, raised again
        ilim = 1'b1;
        cyc(100);
        chk("ilim_raised", 8'h01, {7'h0, ilr});
        cyc(200);
        chk("ilim_base", 8'h00, {7'h0, ilr});
        cyc(200);
        chk("ilim_again", 8'h01, {7'h0, ilr});
        ilim = 1'b0;
        sov = 1'b1;
        cyc(2);
        chk("sw_limit_off", 8'h00, {7'h0, conv_en});
        sov = 1'b0;
        cyc(2);
        chk("sw_limit_on", 8'h01, {7'h0, conv_en});
        // Overvoltage filter: long first, short after a fault, long again later
        ov = 1'b1;
        cyc(300);
        chk("ov_long_early", 8'h00, {7'h0, ovf});
        for (n = 0; n < 200 && ovf !== 1'b1; n++) cyc(1);
        chk("ov_long", 8'h01, {7'h0, ovf});
        cyc(3);
        for (n = 0; n < RC + 100 && st !== LABFC_ACTIVE; n++) cyc(1);
        for (n = 0; n < 400 && ovf !== 1'b1; n++) cyc(1);
        chk("ov_short", 8'h01, {7'h0, n > 150 && n < 250});
        ov = 1'b0;
        cyc(3);
        for (n = 0; n < RC + 100 && st !== LABFC_ACTIVE; n++) cyc(1);
        cyc(400);
        ov = 1'b1;
        cyc(300);
        chk("ov_restored", 8'h00, {7'h0, ovf});
        ov = 1'b0;
        summarize();
    end
endmodule
